// File: logic/power_mode_sequencer.sv
/*
  Power mode sequencer: ON/DOZE/SLEEP/SUSPEND/OFF state machine, inactivity
  timers and panel power-down sequencing.
  Assumes synchronous inputs on clk_sys_i, single-cycle register strobes and a
  one-cycle activity pulse vector from peripheral monitors.
*/
// Strobed register access was decided locally.
`timescale 1ns/100ps
module power_mode_sequencer #(
  parameter longint SEQ_UNIT_CYCLES = pm_seq_pkg::SEQ_STEP_MIN_CYC,
  parameter longint TICK_CYCLES = pm_seq_pkg::TIMER_TICK_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire pm_seq_pkg::reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] activity_i,
  input wire pm_seq_pkg::wake_s wake_i,
  output pm_seq_pkg::panel_pins_s panel_o,
  output logic processor_clock_slow_o,
  output logic timeout_irq_o,
  output logic wake_nmi_o,
  output logic suspend_done_o,
  output logic [2:0] state_o
);
  import pm_seq_pkg::*;

  // ==========================================================================
  // Registers
  logic [7:0] activity_mask_reg;
  logic [7:0] nmi_mask_reg;
  logic [7:0] doze_timer_reg;
  logic [7:0] sleep_timer_reg;
  logic [7:0] suspend_timer_reg;
  logic [7:0] panel_mode_reg;
  logic [7:0] panel_polarity_reg;
  logic [7:0] pm_control_reg;
  logic timeout_irq_reg;
  logic wake_nmi_reg;
  pm_state_e state_reg;
  pm_state_e state_next;
  seq_state_e seq_reg;
  logic panel_on_reg;
  logic clamp_reg;
  logic bias_on_reg;
  logic [31:0] seq_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic [7:0] idle_cnt_reg;
  logic [7:0] rdata_reg;
  logic suspend_done_reg;

  logic wr_en;
  logic status_wr;
  logic [2:0] wr_state;
  logic activity;
  logic tick;
  logic [7:0] active_limit;
  logic timed_out;
  logic panel_want;
  logic [31:0] seq_limit;
  logic wake_any;

  assign wr_en = reg_req_i.wr;
  assign status_wr = wr_en && (reg_req_i.addr == IDX_PM_STATUS);
  assign wr_state = reg_req_i.wdata[STATUS_STATE_LSB +: 3];
  assign activity = |(activity_i & ~activity_mask_reg);
  assign wake_any = wake_i.external_wake_switch | wake_i.ring_indicate_input |
                    wake_i.card_ring_signal | wake_i.rtc_alarm;

  // ==========================================================================
  // Register writes
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      activity_mask_reg <= RST_ACTIVITY_MASK;
      nmi_mask_reg <= RST_NMI_MASK;
      doze_timer_reg <= RST_TIMER;
      sleep_timer_reg <= RST_TIMER;
      suspend_timer_reg <= RST_TIMER;
      panel_mode_reg <= RST_PANEL_MODE;
      panel_polarity_reg <= RST_PANEL_POLARITY;
      pm_control_reg <= RST_PM_CONTROL;
    end else if (wr_en) begin
      case (reg_req_i.addr)
        IDX_ACTIVITY_MASK: activity_mask_reg <= reg_req_i.wdata;
        IDX_NMI_MASK: nmi_mask_reg <= reg_req_i.wdata;
        IDX_DOZE_TIMER: doze_timer_reg <= reg_req_i.wdata;
        IDX_SLEEP_TIMER: sleep_timer_reg <= reg_req_i.wdata;
        IDX_SUSPEND_TIMER: suspend_timer_reg <= reg_req_i.wdata;
        IDX_PANEL_MODE: panel_mode_reg <= reg_req_i.wdata;
        IDX_PANEL_POLARITY: panel_polarity_reg <= reg_req_i.wdata;
        IDX_PM_CONTROL: pm_control_reg <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Register reads, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        IDX_ACTIVITY_MASK: rdata_reg <= activity_mask_reg;
        IDX_NMI_MASK: rdata_reg <= nmi_mask_reg;
        IDX_DOZE_TIMER: rdata_reg <= doze_timer_reg;
        IDX_SLEEP_TIMER: rdata_reg <= sleep_timer_reg;
        IDX_SUSPEND_TIMER: rdata_reg <= suspend_timer_reg;
        IDX_PANEL_MODE: rdata_reg <= panel_mode_reg;
        IDX_PANEL_POLARITY: rdata_reg <= panel_polarity_reg;
        IDX_PM_CONTROL: rdata_reg <= pm_control_reg;
        IDX_PM_STATUS: rdata_reg <= {seq_reg != SEQ_IDLE, panel_on_reg, wake_nmi_reg,
                                     timeout_irq_reg, 1'b0, state_o};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign reg_rdata_o = rdata_reg;

  // ==========================================================================
  // Inactivity timers: one shared counter, since only one timer is live per state
  always_comb begin
    case (state_reg)
      PM_ON: active_limit = doze_timer_reg;
      PM_DOZE: active_limit = sleep_timer_reg;
      PM_SLEEP: active_limit = suspend_timer_reg;
      default: active_limit = 8'h00;
    endcase
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  assign timed_out = (active_limit != 8'h00) && (idle_cnt_reg == active_limit);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      idle_cnt_reg <= 8'h00;
    end else if (activity || state_next != state_reg || status_wr) begin
      idle_cnt_reg <= 8'h00;
    end else if (tick && active_limit != 8'h00 && !timed_out) begin
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
    end
  end

  // ==========================================================================
  // Mode state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PM_ON: begin
        if (timed_out) state_next = PM_DOZE;
      end
      PM_DOZE: begin
        if (activity) begin
          state_next = PM_ON;
        end else if (timed_out && nmi_mask_reg[NMI_SLEEP_AUTO_SELECT_BIT]) begin
          state_next = PM_SLEEP;
        end
      end
      PM_SLEEP: begin
        if (activity && !nmi_mask_reg[NMI_SLEEP_WAKE_NMI_BIT]) state_next = PM_ON;
      end
      PM_SUSPEND, PM_OFF: begin
        if (wake_any && seq_reg == SEQ_IDLE && !panel_on_reg) state_next = PM_ON;
      end
      default: state_next = PM_ON;
    endcase
    if (status_wr) begin
      case (wr_state)
        STATE_CODE_ON: state_next = PM_ON;
        STATE_CODE_DOZE: state_next = PM_DOZE;
        STATE_CODE_SLEEP: state_next = PM_SLEEP;
        STATE_CODE_SUSPEND: state_next = PM_SUSPEND;
        STATE_CODE_OFF: state_next = PM_OFF;
        default: state_next = state_next;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= PM_ON;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    case (state_reg)
      PM_DOZE: state_o = STATE_CODE_DOZE;
      PM_SLEEP: state_o = STATE_CODE_SLEEP;
      PM_SUSPEND: state_o = STATE_CODE_SUSPEND;
      PM_OFF: state_o = STATE_CODE_OFF;
      default: state_o = STATE_CODE_ON;
    endcase
  end

  // ==========================================================================
  // Sticky event flags; a new event beats a clearing status write
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      timeout_irq_reg <= 1'b0;
    end else if (state_reg == PM_DOZE && timed_out && !activity && !nmi_mask_reg[NMI_SLEEP_AUTO_SELECT_BIT]) begin
      timeout_irq_reg <= 1'b1;
    end else if (status_wr && reg_req_i.wdata[STATUS_TIMEOUT_IRQ_BIT]) begin
      timeout_irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wake_nmi_reg <= 1'b0;
    end else if (state_reg == PM_SLEEP && activity && nmi_mask_reg[NMI_SLEEP_WAKE_NMI_BIT]) begin
      wake_nmi_reg <= 1'b1;
    end else if (status_wr && reg_req_i.wdata[STATUS_WAKE_NMI_BIT]) begin
      wake_nmi_reg <= 1'b0;
    end
  end
  assign timeout_irq_o = timeout_irq_reg;
  assign wake_nmi_o = wake_nmi_reg;

  // ==========================================================================
  // Processor clock slowing: optional in DOZE, always in SLEEP
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      processor_clock_slow_o <= 1'b0;
    end else begin
      processor_clock_slow_o <= (state_next == PM_SLEEP) ||
                                (state_next == PM_DOZE && pm_control_reg[CTRL_DOZE_DIVIDE_BIT]);
    end
  end

  // ==========================================================================
  // Panel power sequencing
  assign panel_want = (state_reg == PM_ON) || (state_reg == PM_DOZE) ||
                      (state_reg == PM_SLEEP && !pm_control_reg[CTRL_PANEL_OFF_IN_SLEEP_BIT]);
  // Step length N+1 units from the two delay bits
  assign seq_limit = 32'(SEQ_UNIT_CYCLES * (longint'(panel_mode_reg[MODE_DELAY_LSB +: 2]) + 1) - 1);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      seq_reg <= SEQ_IDLE;
      panel_on_reg <= 1'b1;
      bias_on_reg <= 1'b1;
      clamp_reg <= 1'b0;
      seq_cnt_reg <= 32'h0;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          seq_cnt_reg <= 32'h0;
          if (panel_on_reg && !panel_want) begin
            if (panel_mode_reg[MODE_DOWN_SEQ_ENABLE_BIT]) begin
              bias_on_reg <= 1'b0;
              seq_reg <= SEQ_BIAS_OFF;
            end else begin
              bias_on_reg <= 1'b0;
              clamp_reg <= 1'b1;
              panel_on_reg <= 1'b0;
            end
          end else if (!panel_on_reg && panel_want) begin
            // Power-up ordering is not handled here; all rails return together
            bias_on_reg <= 1'b1;
            clamp_reg <= 1'b0;
            panel_on_reg <= 1'b1;
          end
        end
        SEQ_BIAS_OFF: begin
          seq_cnt_reg <= seq_cnt_reg + 32'h1;
          if (seq_cnt_reg == seq_limit) begin
            clamp_reg <= 1'b1;
            seq_cnt_reg <= 32'h0;
            seq_reg <= SEQ_CLAMPED;
          end
        end
        SEQ_CLAMPED: begin
          seq_cnt_reg <= seq_cnt_reg + 32'h1;
          if (seq_cnt_reg == seq_limit) begin
            panel_on_reg <= 1'b0;
            seq_reg <= SEQ_IDLE;
          end
        end
        default: seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Off rails float; external resistors hold the power switches off
  always_comb begin
    panel_o.logic_o = panel_polarity_reg[POL_LOGIC_BIT];
    panel_o.logic_oe = panel_on_reg;
    panel_o.bias_o = panel_polarity_reg[POL_BIAS_BIT];
    panel_o.bias_oe = bias_on_reg;
    panel_o.clamp = clamp_reg;
  end

  // Suspend is only complete once the panel is fully down
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      suspend_done_reg <= 1'b0;
    end else begin
      suspend_done_reg <= (state_reg == PM_SUSPEND) && !panel_on_reg && seq_reg == SEQ_IDLE;
    end
  end
  assign suspend_done_o = suspend_done_reg;

  // ==========================================================================
  // Assertions
  a_reset_to_on: assert property (@(posedge clk_sys_i)
    !sys_rst_i && $past(sys_rst_i) |-> state_o == STATE_CODE_ON)
    else $error("state not ON after reset");
  a_seq_order_bias: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(panel_o.logic_oe) && $past(panel_mode_reg[MODE_DOWN_SEQ_ENABLE_BIT]) |-> !panel_o.bias_oe && panel_o.clamp)
    else $error("logic rail dropped before bias off and clamp");
  a_unseq_together: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(bias_on_reg) && !$past(panel_mode_reg[MODE_DOWN_SEQ_ENABLE_BIT]) |-> !panel_on_reg && clamp_reg)
    else $error("unsequenced power-off not simultaneous");
  a_seq_gated: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    seq_reg == SEQ_IDLE && $past(seq_reg) == SEQ_IDLE && $fell(bias_on_reg) |-> !panel_on_reg)
    else $error("ordering without enable");
  a_suspend_panel: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    suspend_done_o |-> !$past(panel_on_reg))
    else $error("suspend done with panel powered");
  a_doze_wake: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_reg == PM_DOZE && activity && !status_wr |=> state_reg == PM_ON)
    else $error("doze did not return on activity");
  a_sleep_auto: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_reg == PM_DOZE && timed_out && !activity && !status_wr && nmi_mask_reg[NMI_SLEEP_AUTO_SELECT_BIT]
    |=> state_reg == PM_SLEEP)
    else $error("no automatic sleep");
  a_sleep_irq: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_reg == PM_DOZE && timed_out && !activity && !status_wr && !nmi_mask_reg[NMI_SLEEP_AUTO_SELECT_BIT]
    |=> state_reg == PM_DOZE && timeout_irq_o)
    else $error("sleep timeout did not interrupt");
  a_sleep_nmi_stay: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_reg == PM_SLEEP && activity && !status_wr && nmi_mask_reg[NMI_SLEEP_WAKE_NMI_BIT]
    |=> state_reg == PM_SLEEP && wake_nmi_o)
    else $error("sleep nmi case left sleep");
  a_sw_state: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    status_wr && wr_state == STATE_CODE_ON |=> state_o == STATE_CODE_ON)
    else $error("software ON write ignored");
  a_doze_timeout: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_reg == PM_ON && timed_out && !status_wr |=> state_reg == PM_DOZE)
    else $error("doze timeout ignored");

endmodule

// File: shared/pm_seq_pkg.sv
/*
  Package for the power mode sequencer: register indices, field positions,
  reset values, timing figures, state encoding and grouped signal types.
  Assumes a byte-wide indexed register port driven by processor software.
*/
package pm_seq_pkg;

  // ==========================================================================
  // Register indices (byte-wide, indexed space)
  localparam logic [7:0] IDX_ACTIVITY_MASK = 8'hc3;
  localparam logic [7:0] IDX_NMI_MASK = 8'hc4;
  localparam logic [7:0] IDX_DOZE_TIMER = 8'hcc;
  localparam logic [7:0] IDX_SLEEP_TIMER = 8'hcd;
  localparam logic [7:0] IDX_SUSPEND_TIMER = 8'hce;
  localparam logic [7:0] IDX_PM_STATUS = 8'hc5;
  localparam logic [7:0] IDX_PANEL_MODE = 8'hd0;
  localparam logic [7:0] IDX_PANEL_POLARITY = 8'hca;
  localparam logic [7:0] IDX_PM_CONTROL = 8'hd1;

  // ==========================================================================
  // Field positions
  localparam int NMI_SLEEP_AUTO_SELECT_BIT = 7;
  localparam int NMI_SLEEP_WAKE_NMI_BIT = 6;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_TIMEOUT_IRQ_BIT = 4;
  localparam int STATUS_WAKE_NMI_BIT = 5;
  localparam int STATUS_PANEL_ON_BIT = 6;
  localparam int STATUS_SEQ_BUSY_BIT = 7;
  localparam int MODE_DOWN_SEQ_ENABLE_BIT = 7;
  localparam int MODE_DELAY_LSB = 0;
  localparam int POL_LOGIC_BIT = 0;
  localparam int POL_BIAS_BIT = 1;
  localparam int CTRL_PANEL_OFF_IN_SLEEP_BIT = 0;
  localparam int CTRL_DOZE_DIVIDE_BIT = 1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_ACTIVITY_MASK = 8'h00;
  localparam logic [7:0] RST_NMI_MASK = 8'h80;
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [7:0] RST_PANEL_MODE = 8'h00;
  localparam logic [7:0] RST_PANEL_POLARITY = 8'h03;
  localparam logic [7:0] RST_PM_CONTROL = 8'h01;

  // ==========================================================================
  // Timing: each panel step lasts (delay field + 1) units of 10 ms, so the
  // two-step power-down spans 20 to 80 ms, inside the allowed 20 to 180 ms.
  localparam int CLK_MHZ = 250;
  localparam int SEQ_STEP_MIN_MS = 10;
  localparam int SEQ_STEP_MAX_MS = 90;
  localparam longint SEQ_STEP_MIN_CYC = longint'(SEQ_STEP_MIN_MS) * 1000 * CLK_MHZ;
  localparam int TIMER_TICK_US = 1000;
  localparam longint TIMER_TICK_CYC = longint'(TIMER_TICK_US) * CLK_MHZ;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {PM_ON, PM_DOZE, PM_SLEEP, PM_SUSPEND, PM_OFF} pm_state_e;
  localparam logic [2:0] STATE_CODE_ON = 3'h0;
  localparam logic [2:0] STATE_CODE_DOZE = 3'h1;
  localparam logic [2:0] STATE_CODE_SLEEP = 3'h2;
  localparam logic [2:0] STATE_CODE_SUSPEND = 3'h3;
  localparam logic [2:0] STATE_CODE_OFF = 3'h4;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_BIAS_OFF, SEQ_CLAMPED} seq_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic logic_o;
    logic logic_oe;
    logic bias_o;
    logic bias_oe;
    logic clamp;
  } panel_pins_s;

  typedef struct packed {
    logic external_wake_switch;
    logic ring_indicate_input;
    logic card_ring_signal;
    logic rtc_alarm;
  } wake_s;

endpackage

// File: sim/panel_switch_model.sv
/*
  Panel rail switches with pull resistors on the logic and bias rails.
  Assumes the sequencer drives panel_o and the bench gives the rail polarity.
*/
`timescale 1ns/100ps
module panel_switch_model (
  input wire pm_seq_pkg::panel_pins_s panel_i,
  input wire logic logic_pol_i,
  input wire logic bias_pol_i,
  output logic logic_on_o,
  output logic bias_on_o
);
  import pm_seq_pkg::*;
  // ==========================================================================
  // Rail levels
  logic logic_pin;
  logic bias_pin;
  // A released rail settles at the pulled off level, never at its last value
  assign logic_pin = panel_i.logic_oe ? panel_i.logic_o : ~logic_pol_i;
  assign bias_pin = panel_i.bias_oe ? panel_i.bias_o : ~bias_pol_i;
  assign logic_on_o = (logic_pin == logic_pol_i);
  assign bias_on_o = (bias_pin == bias_pol_i);
endmodule

// File: sim/power_mode_sequencer_tb_top.sv
/*
  Self-checking bench for the power mode sequencer.
  Assumes shortened step and tick counts of 4 cycles and a 250 MHz clock.
*/
`timescale 1ns/100ps
module power_mode_sequencer_tb_top;
  import pm_seq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_s req = '0;
  wake_s wake = '0;
  logic [7:0] act = 8'h00;
  logic [7:0] rdata;
  panel_pins_s panel;
  logic slow, irq, nmi, sdone, logic_on, bias_on;
  logic [2:0] state;
  int n_fail = 0;
  int n_tests = 0;
  int n;

  always #2 clk = ~clk;

  power_mode_sequencer #(.SEQ_UNIT_CYCLES(4), .TICK_CYCLES(4)) i_power_mode_sequencer (
    .clk_sys_i(clk), .sys_rst_i(rst), .reg_req_i(req), .reg_rdata_o(rdata), .activity_i(act),
    .wake_i(wake), .panel_o(panel), .processor_clock_slow_o(slow), .timeout_irq_o(irq),
    .wake_nmi_o(nmi), .suspend_done_o(sdone), .state_o(state));

  panel_switch_model i_panel_switch_model (
    .panel_i(panel), .logic_pol_i(1'b1), .bias_pol_i(1'b1), .logic_on_o(logic_on), .bias_on_o(bias_on));

  // ==========================================================================
  // Shared tasks
  task automatic stop_test();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    act <= m;
    @(posedge clk);
    act <= 8'h00;
  endtask

  task automatic wait_state(input logic [2:0] c, input int lim);
    for (n = 0; n < lim && state !== c; n++) begin
      @(posedge clk);
      #1;
    end
    chk(8'(state), 8'(c));
    if (state !== c) stop_test();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk(8'(state), 8'(STATE_CODE_ON));
    rd(IDX_PM_STATUS, 8'h40);
    rd(IDX_NMI_MASK, RST_NMI_MASK);
    rd(IDX_DOZE_TIMER, RST_TIMER);
    rd(IDX_PANEL_MODE, RST_PANEL_MODE);
    rd(8'h00, 8'h00);
    wr(IDX_ACTIVITY_MASK, 8'h5a);
    rd(IDX_ACTIVITY_MASK, 8'h5a);
    $display("done reset");
  endtask

  task automatic t_doze();
    wr(IDX_ACTIVITY_MASK, 8'h01);
    wr(IDX_DOZE_TIMER, 8'h03);
    for (int i = 0; i < 4; i++) pulse(8'h02);
    chk(8'(state), 8'(STATE_CODE_ON));
    wait_state(STATE_CODE_DOZE, 60);
    chk(8'(slow), 8'h00);
    wr(IDX_PM_CONTROL, 8'h03);
    pulse(8'h01);
    repeat (3) @(posedge clk);
    chk(8'(state), 8'(STATE_CODE_DOZE));
    chk(8'(slow), 8'h01);
    pulse(8'h02);
    wait_state(STATE_CODE_ON, 3);
    $display("done doze");
  endtask

  task automatic t_sleep();
    wr(IDX_SLEEP_TIMER, 8'h02);
    wait_state(STATE_CODE_SLEEP, 100);
    chk(8'(slow), 8'h01);
    repeat (2) @(posedge clk);
    chk({6'h00, logic_on, bias_on}, 8'h00);
    pulse(8'h02);
    wait_state(STATE_CODE_ON, 3);
    wr(IDX_NMI_MASK, 8'h00);
    wait_state(STATE_CODE_DOZE, 60);
    for (n = 0; n < 60 && irq !== 1'b1; n++) @(posedge clk);
    chk(8'(irq), 8'h01);
    chk(8'(state), 8'(STATE_CODE_DOZE));
    wr(IDX_DOZE_TIMER, 8'h00);
    // The timeout is still live in this cycle, so it beats the clear
    wr(IDX_PM_STATUS, 8'h10);
    #1;
    chk(8'(irq), 8'h01);
    chk(8'(state), 8'(STATE_CODE_ON));
    wr(IDX_PM_STATUS, 8'h10);
    #1;
    chk(8'(irq), 8'h00);
    $display("done sleep");
  endtask

  task automatic t_nmi();
    wr(IDX_NMI_MASK, 8'hc0);
    wr(IDX_PM_STATUS, {5'h00, STATE_CODE_SLEEP});
    wait_state(STATE_CODE_SLEEP, 3);
    pulse(8'h02);
    repeat (3) @(posedge clk);
    chk(8'(nmi), 8'h01);
    chk(8'(state), 8'(STATE_CODE_SLEEP));
    wr(IDX_PM_STATUS, 8'h20);
    wait_state(STATE_CODE_ON, 3);
    chk(8'(nmi), 8'h00);
    $display("done nmi");
  endtask

  task automatic t_suspend();
    wr(IDX_PM_STATUS, {5'h00, STATE_CODE_SUSPEND});
    for (n = 0; n < 10 && bias_on === 1'b1; n++) @(posedge clk);
    #1;
    chk({5'h00, logic_on, bias_on, panel.clamp}, 8'h01);
    for (n = 0; n < 10 && sdone !== 1'b1; n++) @(posedge clk);
    chk(8'(sdone), 8'h01);
    @(posedge clk);
    wake.ring_indicate_input <= 1'b1;
    wait_state(STATE_CODE_ON, 20);
    wake.ring_indicate_input <= 1'b0;
    $display("done suspend");
  endtask

  // Two steps of (0+1)*4 cycles stand for the shortest 20 ms power-down
  task automatic t_seq();
    wr(IDX_PANEL_MODE, 8'h80);
    wr(IDX_PM_STATUS, {5'h00, STATE_CODE_OFF});
    for (n = 0; n < 10 && bias_on === 1'b1; n++) @(posedge clk);
    #1;
    chk({6'h00, logic_on, panel.clamp}, 8'h02);
    for (n = 0; n < 20 && panel.clamp !== 1'b1; n++) @(posedge clk);
    chk(8'(n), 8'h04);
    chk(8'(logic_on), 8'h01);
    for (n = 0; n < 20 && logic_on === 1'b1; n++) @(posedge clk);
    chk(8'(n), 8'h04);
    wake.rtc_alarm <= 1'b1;
    wait_state(STATE_CODE_ON, 40);
    wake.rtc_alarm <= 1'b0;
    // Software leaves ordered power-down off in normal use
    wr(IDX_PANEL_MODE, 8'h00);
    $display("done seq");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_doze();
    t_sleep();
    t_nmi();
    t_suspend();
    t_seq();
    stop_test();
  end
endmodule
